// ==== hw/dsf_fault_response.sv ====
// Purpose : Reaction of the output to driver-supply over- and undervoltage faults
// Assumes : Threshold comparison is done outside; command port is a decoded PMBus byte access
// Notes   : Overvoltage wins when both faults arrive in the same cycle
`timescale 1ns/1ps

module dsf_fault_response #(
  parameter int unsigned UNIT_CYC = dsf_pkg::DELAY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Decoded command port
  input  wire logic [7:0] cmd_code,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_wdata,
  output logic      [7:0] cmd_rdata,
  output logic            cmd_ack,
  output logic            cmd_nack,
  // Supply monitor comparators and system control
  input  wire logic       ov_detect,
  input  wire logic       uv_detect,
  input  wire logic       run_cmd,
  input  wire logic       other_shutdown,
  input  wire logic       clear_faults,
  // Outputs
  output logic            alert_out_n,
  output logic            power_enable,
  output logic            ov_fault_flag,
  output logic            uv_fault_flag
);
  import dsf_pkg::*;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,  // Output follows run_cmd
    ST_DELAY = 3'b010,  // Off, waiting for next restart
    ST_HOLD  = 3'b100   // Off until faults are cleared
  } dsf_state_e;

  dsf_state_e state_reg, state_next;
  logic [7:0] ov_cfg_reg,  ov_cfg_next;   // Overvoltage reaction byte
  logic [7:0] uv_cfg_reg,  uv_cfg_next;   // Undervoltage reaction byte
  logic [2:0] left_reg,    left_next;     // Restarts still allowed
  logic       inf_reg,     inf_next;      // Unlimited retries in force
  logic       seq_reg,     seq_next;      // A retry sequence is under way
  logic       pwr_reg,     pwr_next;      // Output enable
  logic       ovf_reg,     ovf_next;      // Sticky overvoltage flag
  logic       uvf_reg,     uvf_next;      // Sticky undervoltage flag
  logic       alert_reg,   alert_next;    // Alert, active low
  logic [7:0] rdata_reg,   rdata_next;    // Read data
  logic       ack_reg,     ack_next;      // Mapped access answered
  logic       nack_reg,    nack_next;     // Unmapped access refused

  // Combinational helpers
  logic       ov_hit;     // Overvoltage with shutdown reaction
  logic       uv_hit;     // Undervoltage with shutdown reaction
  logic [7:0] act_cfg;    // Reaction byte of the fault being handled
  logic [2:0] eff_left;   // Restarts available for this fault
  logic       eff_inf;    // Unlimited for this fault
  logic       mapped;     // Command code is one of ours

  dsf_timer_if tif ();

  dsf_retry_timer #(.UNIT_CYC(UNIT_CYC)) u_dsf_retry_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .tif    (tif)
  );

  // ----------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------
  // Comparators judge each fault against its own threshold
  assign ov_hit   = ov_detect && (ov_cfg_reg[RESP_MSB:RESP_LSB] == RESP_DISABLE_RETRY);
  assign uv_hit   = uv_detect && (uv_cfg_reg[RESP_MSB:RESP_LSB] == RESP_DISABLE_RETRY);
  assign act_cfg  = ov_hit ? ov_cfg_reg : uv_cfg_reg;
  // A fresh fault loads its own count; a running sequence keeps its budget
  assign eff_left = seq_reg ? left_reg : act_cfg[RETRY_MSB:RETRY_LSB];
  assign eff_inf  = seq_reg ? inf_reg : (act_cfg[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER);
  assign mapped   = (cmd_code == OFS_OV_REACTION) || (cmd_code == OFS_UV_REACTION);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    left_next   = left_reg;
    inf_next    = inf_reg;
    seq_next    = seq_reg;
    pwr_next    = 1'b0;
    tif.start   = 1'b0;
    tif.abort   = 1'b0;
    tif.code    = act_cfg[DELAY_MSB:DELAY_LSB];
    ov_cfg_next = ov_cfg_reg;
    uv_cfg_next = uv_cfg_reg;
    rdata_next  = rdata_reg;
    ack_next    = 1'b0;
    nack_next   = 1'b0;

    // Reaction registers
    if (cmd_wr && cmd_code == OFS_OV_REACTION) begin
      ov_cfg_next = cmd_wdata;
    end
    if (cmd_wr && cmd_code == OFS_UV_REACTION) begin
      uv_cfg_next = cmd_wdata;
    end
    if (cmd_rd) begin
      rdata_next = (cmd_code == OFS_OV_REACTION) ? ov_cfg_reg :
                   (cmd_code == OFS_UV_REACTION) ? uv_cfg_reg : 8'h00;
    end
    if (cmd_wr || cmd_rd) begin
      ack_next  = mapped;
      nack_next = !mapped;
    end

    // Sticky flags; a new fault beats a clear in the same cycle
    ovf_next   = ov_detect || (ovf_reg && !clear_faults);
    uvf_next   = uv_detect || (uvf_reg && !clear_faults);
    alert_next = !(ovf_next || uvf_next);

    unique case (state_reg)
      ST_RUN: begin
        pwr_next = run_cmd;
        if (!run_cmd) begin
          // Commanded off ends any retry sequence
          seq_next = 1'b0;
        end else if (ov_hit || uv_hit) begin
          pwr_next = 1'b0;
          seq_next = 1'b1;
          inf_next = eff_inf;
          left_next = eff_left;
          if (eff_left == RETRY_NONE && !eff_inf) begin
            // No attempts left, or none asked for
            state_next = ST_HOLD;
          end else begin
            tif.start  = 1'b1;
            state_next = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        if (!run_cmd) begin
          tif.abort  = 1'b1;
          seq_next   = 1'b0;
          state_next = ST_RUN;
        end else if (other_shutdown) begin
          // Another fault holds the output off until faults are cleared
          tif.abort  = 1'b1;
          state_next = ST_HOLD;
        end else if (tif.done) begin
          // Restart attempt
          pwr_next   = 1'b1;
          state_next = ST_RUN;
          if (!inf_reg) begin
            left_next = left_reg - 3'h1;
          end
        end
      end
      ST_HOLD: begin
        // Leaves only once faults are cleared and gone
        if (clear_faults && !ov_detect && !uv_detect) begin
          seq_next   = 1'b0;
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= ST_RUN;
      ov_cfg_reg <= REACTION_RST;
      uv_cfg_reg <= REACTION_RST;
      left_reg   <= 3'h0;
      inf_reg    <= 1'b0;
      seq_reg    <= 1'b0;
      pwr_reg    <= 1'b0;
      ovf_reg    <= 1'b0;
      uvf_reg    <= 1'b0;
      alert_reg  <= 1'b1;
      rdata_reg  <= 8'h00;
      ack_reg    <= 1'b0;
      nack_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ov_cfg_reg <= ov_cfg_next;
      uv_cfg_reg <= uv_cfg_next;
      left_reg   <= left_next;
      inf_reg    <= inf_next;
      seq_reg    <= seq_next;
      pwr_reg    <= pwr_next;
      ovf_reg    <= ovf_next;
      uvf_reg    <= uvf_next;
      alert_reg  <= alert_next;
      rdata_reg  <= rdata_next;
      ack_reg    <= ack_next;
      nack_reg   <= nack_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign cmd_rdata     = rdata_reg;
  assign cmd_ack       = ack_reg;
  assign cmd_nack      = nack_reg;
  assign alert_out_n   = alert_reg;
  assign power_enable  = pwr_reg;
  assign ov_fault_flag = ovf_reg;
  assign uv_fault_flag = uvf_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ov_write;
    @(posedge clock) disable iff (!arst_n)
    (cmd_wr && cmd_code == OFS_OV_REACTION) |=> (ov_cfg_reg == $past(cmd_wdata));
  endproperty
  a_ov_write: assert property (p_ov_write) else $error("overvoltage reaction not written");

  property p_uv_write;
    @(posedge clock) disable iff (!arst_n)
    (cmd_wr && cmd_code == OFS_UV_REACTION) |=> (uv_cfg_reg == $past(cmd_wdata));
  endproperty
  a_uv_write: assert property (p_uv_write) else $error("undervoltage reaction not written");

  property p_alert;
    @(posedge clock) disable iff (!arst_n)
    (ov_detect || uv_detect) |=> (!alert_out_n && (ov_fault_flag || uv_fault_flag));
  endproperty
  a_alert: assert property (p_alert) else $error("fault did not raise alert and flag");

  property p_off_now;
    @(posedge clock) disable iff (!arst_n)
    (state_reg == ST_RUN && (ov_hit || uv_hit)) |=> !power_enable;
  endproperty
  a_off_now: assert property (p_off_now) else $error("output not shut off at once");

  property p_no_retry;
    @(posedge clock) disable iff (!arst_n)
    (state_reg == ST_RUN && run_cmd && (ov_hit || uv_hit) && eff_left == RETRY_NONE && !eff_inf)
      |=> (state_reg == ST_HOLD) [*2];
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart attempted with no retries");

  property p_forever;
    @(posedge clock) disable iff (!arst_n)
    (state_reg == ST_DELAY && inf_reg && tif.done && run_cmd && !other_shutdown)
      |=> (state_reg == ST_RUN && power_enable && inf_reg);
  endproperty
  a_forever: assert property (p_forever) else $error("unlimited retry stopped");

  property p_count_down;
    @(posedge clock) disable iff (!arst_n)
    (state_reg == ST_DELAY && !inf_reg && tif.done && run_cmd && !other_shutdown)
      |=> (left_reg == $past(left_reg) - 3'h1);
  endproperty
  a_count_down: assert property (p_count_down) else $error("retry budget not spent");

  property p_hold;
    @(posedge clock) disable iff (!arst_n)
    (state_reg == ST_HOLD && !clear_faults) |=> (state_reg == ST_HOLD && !power_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("left hold without clear");

endmodule

// ==== hw/dsf_pkg.sv ====
// Purpose : Shared constants for the driver-supply fault response block
// Assumes : 200 MHz clock; command codes arrive already decoded from PMBus
// Notes   : Every offset, field position, reset value and time lives here once
package dsf_pkg;

  // ----------------------------------------------------------------
  // Command codes of the two reaction registers
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OV_REACTION = 8'hF8;  // Overvoltage reaction
  localparam logic [7:0] OFS_UV_REACTION = 8'hF9;  // Undervoltage reaction

  // ----------------------------------------------------------------
  // Field layout, shared by both registers
  // ----------------------------------------------------------------
  localparam int RESP_MSB  = 7;  // Response field [7:6]
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;  // Retry count field [5:3]
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;  // Retry delay field [2:0]
  localparam int DELAY_LSB = 0;

  // ----------------------------------------------------------------
  // Encodings and reset value
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;  // Shut down and retry
  localparam logic [2:0] RETRY_NONE         = 3'h0;  // No restart attempt
  localparam logic [2:0] RETRY_FOREVER      = 3'h7;  // Restart without limit
  localparam logic [7:0] REACTION_RST       = 8'h80; // Shut down, no retry, shortest delay

  // ----------------------------------------------------------------
  // Timing: one delay step, and its count of clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 200000;                       // 200 MHz
  localparam int unsigned DELAY_UNIT_MS = 35;                           // Step of the retry delay
  localparam int unsigned DELAY_UNIT_CYC = DELAY_UNIT_MS * CLK_KHZ;     // Cycles per step

endpackage

// ==== hw/dsf_timer_if.sv ====
// Purpose : Carries start, abort, delay code and expiry between control and timer
// Assumes : Single clock domain
// Notes   : start and abort are one-cycle pulses; done is a one-cycle pulse
`timescale 1ns/1ps
interface dsf_timer_if;
  logic       start;  // Begin a retry delay
  logic       abort;  // Cancel a running delay
  logic [2:0] code;   // Delay code, valid with start
  logic       done;   // Delay has run out

  modport ctl (output start, output abort, output code, input done);
  modport tmr (input start, input abort, input code, output done);
endinterface

// ==== hw/dsf_retry_timer.sv ====
// Purpose : Retry delay timer, (code + 1) steps of one delay unit each
// Assumes : start and abort never needed together; abort wins if both come
// Notes   : done rises exactly (code + 1) * UNIT_CYC cycles after start
`timescale 1ns/1ps
module dsf_retry_timer #(
  parameter int unsigned UNIT_CYC = dsf_pkg::DELAY_UNIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control side
  dsf_timer_if.tmr tif
);
  import dsf_pkg::*;

  localparam int CW = $clog2(UNIT_CYC + 1);

  logic [CW-1:0] cyc_reg,   cyc_next;    // Cycles left in the current step
  logic [3:0]    units_reg, units_next;  // Steps left, zero when idle
  logic          done_reg,  done_next;   // Expiry pulse

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    cyc_next   = cyc_reg;
    units_next = units_reg;
    done_next  = 1'b0;
    if (tif.abort) begin
      // Cancelled: drop back to idle
      cyc_next   = '0;
      units_next = 4'h0;
    end else if (tif.start) begin
      // Load code + 1 steps
      units_next = {1'b0, tif.code} + 4'h1;
      cyc_next   = CW'(UNIT_CYC - 1);
    end else if (units_reg != 4'h0) begin
      if (cyc_reg == '0) begin
        // Step finished
        units_next = units_reg - 4'h1;
        cyc_next   = CW'(UNIT_CYC - 1);
        done_next  = (units_reg == 4'h1);
      end else begin
        cyc_next = cyc_reg - CW'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg   <= '0;
      units_reg <= 4'h0;
      done_reg  <= 1'b0;
    end else begin
      cyc_reg   <= cyc_next;
      units_reg <= units_next;
      done_reg  <= done_next;
    end
  end

  assign tif.done = done_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_load_steps;
    @(posedge clock) disable iff (!arst_n)
    (tif.start && !tif.abort) |=> (units_reg == ({1'b0, $past(tif.code)} + 4'h1));
  endproperty
  a_load_steps: assert property (p_load_steps) else $error("delay steps not code plus one");

  property p_done_end;
    @(posedge clock) disable iff (!arst_n)
    done_reg |-> ($past(units_reg) == 4'h1 && $past(cyc_reg) == '0 && units_reg == 4'h0);
  endproperty
  a_done_end: assert property (p_done_end) else $error("delay ended at wrong count");

endmodule

// ==== sim/dsf_host_model.sv ====
// Purpose : Host side of the decoded command port, one byte access at a time
// Assumes : Strobes are one-cycle pulses launched on a rising edge
// Notes   : Released code and data show their inverse, never a stale copy
`timescale 1ns/1ps
module dsf_host_model (
  // Clock
  input  wire logic       clock,
  // Command port towards the block
  output logic      [7:0] cmd_code,
  output logic            cmd_wr,
  output logic            cmd_rd,
  output logic      [7:0] cmd_wdata
);
  // ----------------------------------------------------------------
  // Idle values at time zero
  // ----------------------------------------------------------------
  initial begin
    cmd_code  = 8'h00;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // One access: strobe held for the taking edge, then released
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(posedge clock);
    cmd_code  <= code;
    cmd_wdata <= data;
    cmd_wr    <= wr;
    cmd_rd    <= ~wr;
    @(posedge clock);
    cmd_code  <= ~code;   // Inverse so a stale code cannot look valid
    cmd_wdata <= ~data;
    cmd_wr    <= 1'b0;
    cmd_rd    <= 1'b0;
  endtask
endmodule

// ==== sim/dsf_fault_response_tb.sv ====
// Purpose : Self-checking bench for the driver-supply fault response block
// Assumes : Delay step shortened to UNIT cycles; detects come as one-cycle pulses
// Notes   : Outputs are read at the rising edge, so they show the previous edge
`timescale 1ns/1ps
module dsf_fault_response_tb;
  import dsf_pkg::*;
  localparam int unsigned UNIT = 4;  // Short step keeps the run brief
  typedef struct packed {logic rd; logic nack; logic [7:0] data;} dsf_note_s;
  logic       clock, arst_n, cmd_wr, cmd_rd, cmd_ack, cmd_nack;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, v;
  logic       ov_detect, uv_detect, run_cmd, other_shutdown, clear_faults;
  logic       alert_out_n, power_enable, ov_fault_flag, uv_fault_flag, any_on;
  int         failures, n_checks, n;
  integer     seed;
  dsf_note_s  notes[$];
  dsf_note_s  nt;

  dsf_host_model u_dsf_host_model (.clock(clock), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));
  dsf_fault_response #(.UNIT_CYC(UNIT)) u_dsf_fault_response (.clock(clock), .arst_n(arst_n),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .ov_detect(ov_detect),
    .uv_detect(uv_detect), .run_cmd(run_cmd), .other_shutdown(other_shutdown),
    .clear_faults(clear_faults), .alert_out_n(alert_out_n), .power_enable(power_enable),
    .ov_fault_flag(ov_fault_flag), .uv_fault_flag(uv_fault_flag));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Comparison, verdict and command helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Note the expected answer first, then let the host make the access
  task automatic wr(input logic [7:0] code, input logic [7:0] d, input logic nk);
    notes.push_back('{1'b0, nk, 8'h00});
    u_dsf_host_model.access(1'b1, code, d);
  endtask
  task automatic rd(input logic [7:0] code, input logic [7:0] d, input logic nk);
    notes.push_back('{1'b1, nk, d});
    u_dsf_host_model.access(1'b0, code, d);
  endtask

  // ----------------------------------------------------------------
  // Answer watcher: oldest note against each ack or nack pulse
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (arst_n && (cmd_ack === 1'b1 || cmd_nack === 1'b1)) begin
      if (notes.size() == 0) chk(8'h01, 8'h00, "answer with no request");
      else begin
        nt = notes.pop_front();
        chk({7'h00, cmd_nack}, {7'h00, nt.nack}, "answer kind");
        if (nt.rd) chk(cmd_rdata, nt.data, "read data");
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault path helpers
  // ----------------------------------------------------------------
  // One-cycle detect pulse, then outputs one cycle after it is taken
  task automatic fault(input logic ov, input logic off);
    @(posedge clock);
    ov_detect <= ov;
    uv_detect <= ~ov;
    @(posedge clock);
    ov_detect <= 1'b0;
    uv_detect <= 1'b0;
    @(posedge clock);
    chk({7'h00, power_enable}, {7'h00, ~off}, "output after fault");
    chk({7'h00, alert_out_n}, 8'h00, "alert after fault");
    chk({6'h00, ov_fault_flag, uv_fault_flag}, {6'h00, ov, ~ov}, "fault flags");
  endtask
  // Cycles from the output seen off until it is seen on again
  task automatic restart(input int d);
    n = 0;
    while (power_enable !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) begin
      failures++;
      end_of_test();
    end else begin
      chk(n[7:0], 8'((d + 1) * UNIT + 1), "retry delay");
    end
  endtask
  // Output must stay off well past the longest delay in use
  task automatic hold_off();
    any_on = 1'b0;
    repeat (40) begin
      @(posedge clock);
      any_on = any_on | power_enable;
    end
    chk({7'h00, any_on}, 8'h00, "output held off");
  endtask
  // Clear with run low, which also starts a fresh fault sequence
  task automatic clear();
    @(posedge clock);
    clear_faults <= 1'b1;
    run_cmd      <= 1'b0;
    @(posedge clock);
    clear_faults <= 1'b0;
    @(posedge clock);
    run_cmd <= 1'b1;
    repeat (2) @(posedge clock);
    chk({5'h00, alert_out_n, ov_fault_flag, uv_fault_flag}, 8'h04, "flags cleared");
    chk({7'h00, power_enable}, 8'h01, "output back on");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h6101c468;
    failures = 0;
    n_checks = 0;
    {arst_n, ov_detect, uv_detect, run_cmd, other_shutdown, clear_faults} = 6'h00;
    repeat (4) @(posedge clock);
    arst_n  <= 1'b1;
    run_cmd <= 1'b1;
    // Reset values, unmapped codes, random write and read back
    rd(OFS_OV_REACTION, REACTION_RST, 1'b0);
    rd(OFS_UV_REACTION, REACTION_RST, 1'b0);
    rd(8'hF7, 8'h00, 1'b1);
    wr(8'hFA, 8'h5A, 1'b1);
    repeat (4) begin
      v = 8'($random(seed));
      wr(OFS_OV_REACTION, v, 1'b0);
      wr(OFS_UV_REACTION, ~v, 1'b0);
      rd(OFS_OV_REACTION, v, 1'b0);
      rd(OFS_UV_REACTION, ~v, 1'b0);
    end
    repeat (3) @(posedge clock);
    chk(8'(notes.size()), 8'h00, "answers missing");
    // Other response codes: alert and flag only, output untouched
    for (int r = 0; r < 4; r++) begin
      if (r == 2) continue;
      wr(OFS_OV_REACTION, {2'(r), 6'h08}, 1'b0);
      fault(1'b1, 1'b0);
      clear();
    end
    // Every delay code, alternating the two registers
    for (int d = 0; d < 8; d++) begin
      wr(d[0] ? OFS_UV_REACTION : OFS_OV_REACTION, {5'b10001, 3'(d)}, 1'b0);
      fault(~d[0], 1'b1);
      restart(d);
      clear();
    end
    // No retry: off until cleared
    wr(OFS_UV_REACTION, 8'h83, 1'b0);
    fault(1'b0, 1'b1);
    hold_off();
    clear();
    // Three retries exactly, then held off
    wr(OFS_OV_REACTION, 8'h9A, 1'b0);
    fault(1'b1, 1'b1);
    repeat (3) begin
      restart(2);
      fault(1'b1, 1'b1);
    end
    hold_off();
    clear();
    // Unlimited retries, stopped by another shutdown
    wr(OFS_UV_REACTION, 8'hB8, 1'b0);
    fault(1'b0, 1'b1);
    repeat (9) begin
      restart(0);
      fault(1'b0, 1'b1);
    end
    other_shutdown <= 1'b1;
    @(posedge clock);
    other_shutdown <= 1'b0;
    hold_off();
    clear();
    // Commanded off during the delay: the pending restart must not come
    fault(1'b0, 1'b1);
    run_cmd <= 1'b0;
    hold_off();
    clear();
    end_of_test();
  end
endmodule
